// ==== emcc_regs.svh ====
`ifndef EMCC_REGS_SVH
`define EMCC_REGS_SVH

// Memory cycle framing in master clock periods
`define EMCC_CYCLE_SLOTS 6
`define EMCC_LAST_SLOT 3'h5
// DRAM slot windows, inclusive
`define EMCC_RAS_FIRST 3'h1
`define EMCC_RAS_LAST 3'h4
`define EMCC_CAS_FIRST 3'h3
`define EMCC_COL_FIRST 3'h2
`define EMCC_WE_FIRST 3'h1
// Linear memory windows
`define EMCC_OE_FIRST 3'h2
// SDRAM command slots
`define EMCC_SD_ACT_SLOT 3'h1
`define EMCC_SD_RW_SLOT 3'h3
`define EMCC_SD_MRS_SLOT2 3'h2
// SDRAM commands as {ras_n, cas_n, we_n}
`define EMCC_CMD_NOP 3'h7
`define EMCC_CMD_ACT 3'h3
`define EMCC_CMD_RD 3'h5
`define EMCC_CMD_WR 3'h4
`define EMCC_CMD_REF 3'h1
`define EMCC_CMD_PRE 3'h2
`define EMCC_CMD_MRS 3'h0
// Sequential, burst 1, CAS latency 2, standard op, programmed write burst
`define EMCC_SD_MODE 12'h020
`define EMCC_SD_AP_BIT 10
`define EMCC_INIT_REFS 4'h8
// Refresh scheduling
`define EMCC_REF_PERIOD 512
`define EMCC_REF_ROW_W 12

`endif

// ==== emcc_pkg.sv ====
package emcc_pkg;

  typedef enum logic [1:0] {
    EMCC_I_PRE,
    EMCC_I_REF,
    EMCC_I_MRS,
    EMCC_I_RUN
  } emcc_init_t;

  typedef enum logic [3:0] {
    EMCC_K_IDLE,
    EMCC_K_LIN_RD,
    EMCC_K_LIN_WR,
    EMCC_K_DR_RD,
    EMCC_K_DR_WR,
    EMCC_K_DR_REF,
    EMCC_K_SD_RD,
    EMCC_K_SD_WR,
    EMCC_K_SD_REF,
    EMCC_K_SD_PRE,
    EMCC_K_SD_MRS
  } emcc_kind_t;

  typedef struct packed {
    emcc_init_t init;
    emcc_kind_t kind;
    logic [3:0] ref_cnt;
    logic sdram;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cs_n;
    logic oe_n;
    logic [11:0] maddr;
    logic [23:0] laddr;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [15:0] dq;
    logic dq_oe_n;
    logic [15:0] rd_data;
    logic rd_valid;
  } emcc_state_t;

endpackage : emcc_pkg

// ==== emcc_phase.sv ====
`timescale 1ns/1ps
`include "emcc_regs.svh"

module emcc_phase
  import emcc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Slot position
  output logic [2:0] phase,
  output logic last_slot
);

  logic [2:0] phase_r;
  logic [2:0] phase_nxt;

  always_comb
  begin
    phase_nxt = (phase_r == `EMCC_LAST_SLOT) ? 3'h0 : phase_r + 3'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      phase_r <= 3'h0;
    else
      phase_r <= phase_nxt;
  end

  assign phase = phase_r;
  assign last_slot = (phase_r == `EMCC_LAST_SLOT);

  sequence emcc_six_slots_s;
    phase_r == 3'h1 ##1 phase_r == 3'h2 ##1 phase_r == 3'h3 ##1 phase_r == 3'h4
      ##1 phase_r == 3'h5 ##1 phase_r == 3'h0;
  endsequence

  cycle_six_slots_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_r == 3'h0 |=> emcc_six_slots_s)
    else $error("memory cycle is not six slots long");

endmodule : emcc_phase

// ==== emcc_refresh.sv ====
`timescale 1ns/1ps
`include "emcc_regs.svh"

module emcc_refresh
  import emcc_pkg::*;
#(
  parameter int PERIOD = `EMCC_REF_PERIOD,
  parameter int ROW_W = `EMCC_REF_ROW_W
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Refresh handshake
  input wire logic ref_ack,
  output logic ref_pending,
  output logic [ROW_W-1:0] ref_row
);

  localparam int TW = $clog2(PERIOD);

  logic [TW-1:0] tick_r;
  logic pend_r;
  logic [ROW_W-1:0] row_r;
  logic tick_done;

  assign tick_done = (tick_r == TW'(PERIOD - 1));

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tick_r <= '0;
      pend_r <= 1'b0;
      row_r <= '0;
    end
    else
    begin
      tick_r <= tick_done ? '0 : tick_r + TW'(1);
      // A new tick in the ack cycle keeps the request alive
      pend_r <= tick_done | (pend_r & ~ref_ack);
      if (ref_ack)
        row_r <= row_r + ROW_W'(1);
    end
  end

  assign ref_pending = pend_r;
  assign ref_row = row_r;

  refresh_interval_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick_done |=> pend_r && tick_r == '0)
    else $error("refresh request not raised at interval end");

endmodule : emcc_refresh

// ==== emcc_top.sv ====
`timescale 1ns/1ps
`include "emcc_regs.svh"

module emcc_top
  import emcc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Access requests
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic dram_select,
  input wire logic [23:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // Memory address and control
  output logic [23:0] linear_addr,
  output logic [11:0] muxed_addr,
  output logic mem_chip_select_zero_n,
  output logic mem_output_enable_n,
  output logic mem_write_enable_n,
  output logic master_clock_out,
  // Row and column strobes, row strobe sensed during reset
  input wire logic row_strobe_n_in,
  output logic row_strobe_n_out,
  output logic row_strobe_n_oe_n,
  input wire logic col_strobe_n_in,
  output logic col_strobe_n_out,
  output logic col_strobe_n_oe_n,
  // Memory data bus
  input wire logic [15:0] mem_dq_in,
  output logic [15:0] mem_dq_out,
  output logic mem_dq_oe_n
);

  emcc_state_t st_r;
  emcc_state_t st_nxt;
  logic [2:0] phase;
  logic last_slot;
  logic ref_pending;
  logic ref_ack;
  logic [11:0] ref_row;
  logic [2:0] s;
  emcc_kind_t k;
  logic [23:0] a;
  logic [11:0] row_addr;
  logic [11:0] col_addr;
  logic [2:0] cmd;
  logic accept;

  emcc_phase u_phase (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .phase(phase),
    .last_slot(last_slot)
  );

  emcc_refresh #(
    .PERIOD(`EMCC_REF_PERIOD),
    .ROW_W(`EMCC_REF_ROW_W)
  ) u_refresh (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ref_ack(ref_ack),
    .ref_pending(ref_pending),
    .ref_row(ref_row)
  );

  // New work is only taken at the cycle boundary, refresh first
  assign req_ready = last_slot && st_r.init == EMCC_I_RUN && !ref_pending;
  assign accept = req_valid && req_ready;

  always_comb
  begin
    st_nxt = st_r;
    ref_ack = 1'b0;
    s = last_slot ? 3'h0 : phase + 3'h1;
    k = st_r.kind;
    st_nxt.rd_valid = 1'b0;
    if (last_slot)
    begin
      k = EMCC_K_IDLE;
      // Read data are sampled at the end of the last slot
      if (st_r.kind == EMCC_K_LIN_RD || st_r.kind == EMCC_K_DR_RD || st_r.kind == EMCC_K_SD_RD)
      begin
        st_nxt.rd_data = mem_dq_in;
        st_nxt.rd_valid = 1'b1;
      end
      unique case (st_r.init)
        EMCC_I_PRE:
        begin
          if (st_r.sdram)
          begin
            k = EMCC_K_SD_PRE;
            st_nxt.init = EMCC_I_REF;
          end
          else
            st_nxt.init = EMCC_I_RUN;
        end
        EMCC_I_REF:
        begin
          k = EMCC_K_SD_REF;
          st_nxt.ref_cnt = st_r.ref_cnt + 4'h1;
          if (st_r.ref_cnt == `EMCC_INIT_REFS - 4'h1)
            st_nxt.init = EMCC_I_MRS;
        end
        EMCC_I_MRS:
        begin
          k = EMCC_K_SD_MRS;
          st_nxt.init = EMCC_I_RUN;
        end
        EMCC_I_RUN:
        begin
          if (ref_pending)
          begin
            k = st_r.sdram ? EMCC_K_SD_REF : EMCC_K_DR_REF;
            ref_ack = 1'b1;
          end
          else if (accept)
          begin
            st_nxt.addr = req_addr;
            st_nxt.wdata = req_wdata;
            if (!dram_select)
              k = req_write ? EMCC_K_LIN_WR : EMCC_K_LIN_RD;
            else if (st_r.sdram)
              k = req_write ? EMCC_K_SD_WR : EMCC_K_SD_RD;
            else
              k = req_write ? EMCC_K_DR_WR : EMCC_K_DR_RD;
          end
        end
      endcase
    end
    st_nxt.kind = k;
    a = st_nxt.addr;
    row_addr = {a[22], a[20], a[18], a[8:0]};
    col_addr = {a[23], a[21], a[19], a[17:9]};

    // Idle strobes stay parked high to save power
    st_nxt.ras_n = 1'b1;
    st_nxt.cas_n = 1'b1;
    st_nxt.we_n = 1'b1;
    st_nxt.cs_n = 1'b1;
    st_nxt.oe_n = 1'b1;
    st_nxt.dq_oe_n = 1'b1;
    st_nxt.dq = st_r.dq;
    st_nxt.maddr = st_r.maddr;
    st_nxt.laddr = st_r.laddr;
    cmd = `EMCC_CMD_NOP;

    unique case (k)
      EMCC_K_IDLE:
      begin
      end
      EMCC_K_LIN_RD:
      begin
        st_nxt.laddr = a;
        st_nxt.cs_n = 1'b0;
        st_nxt.oe_n = !(s >= `EMCC_OE_FIRST);
      end
      EMCC_K_LIN_WR:
      begin
        st_nxt.laddr = a;
        st_nxt.cs_n = 1'b0;
        st_nxt.we_n = !(s >= `EMCC_WE_FIRST);
        st_nxt.dq = st_nxt.wdata;
        st_nxt.dq_oe_n = !(s >= `EMCC_WE_FIRST);
      end
      EMCC_K_DR_RD, EMCC_K_DR_WR, EMCC_K_DR_REF:
      begin
        st_nxt.laddr = a;
        st_nxt.ras_n = !(s >= `EMCC_RAS_FIRST && s <= `EMCC_RAS_LAST);
        st_nxt.cs_n = !(s >= `EMCC_RAS_FIRST);
        if (k == EMCC_K_DR_REF)
          st_nxt.maddr = ref_row;
        else
        begin
          st_nxt.cas_n = !(s >= `EMCC_CAS_FIRST);
          st_nxt.maddr = (s >= `EMCC_COL_FIRST) ? col_addr : row_addr;
        end
        if (k == EMCC_K_DR_WR)
        begin
          // Early write: set up before CAS, held to cycle end
          st_nxt.we_n = !(s >= `EMCC_WE_FIRST);
          st_nxt.dq = st_nxt.wdata;
          st_nxt.dq_oe_n = !(s >= `EMCC_WE_FIRST);
        end
      end
      EMCC_K_SD_RD, EMCC_K_SD_WR, EMCC_K_SD_REF, EMCC_K_SD_PRE, EMCC_K_SD_MRS:
      begin
        st_nxt.cs_n = 1'b0;
        st_nxt.laddr = a;
        if (s == `EMCC_SD_ACT_SLOT)
        begin
          unique case (k)
            EMCC_K_SD_REF: cmd = `EMCC_CMD_REF;
            EMCC_K_SD_PRE: cmd = `EMCC_CMD_PRE;
            EMCC_K_SD_MRS: cmd = `EMCC_CMD_MRS;
            default: cmd = `EMCC_CMD_ACT;
          endcase
          st_nxt.maddr = row_addr;
          if (k == EMCC_K_SD_PRE)
            st_nxt.maddr[`EMCC_SD_AP_BIT] = 1'b1;
          if (k == EMCC_K_SD_MRS)
            st_nxt.maddr = `EMCC_SD_MODE;
        end
        else if (s == `EMCC_SD_MRS_SLOT2 && k == EMCC_K_SD_MRS)
          cmd = `EMCC_CMD_MRS;
        else if (s == `EMCC_SD_RW_SLOT && (k == EMCC_K_SD_RD || k == EMCC_K_SD_WR))
        begin
          cmd = (k == EMCC_K_SD_WR) ? `EMCC_CMD_WR : `EMCC_CMD_RD;
          st_nxt.maddr = {1'b0, 1'b1, 1'b0, a[17:9]};
          if (k == EMCC_K_SD_WR)
          begin
            st_nxt.dq = st_nxt.wdata;
            st_nxt.dq_oe_n = 1'b0;
          end
        end
        {st_nxt.ras_n, st_nxt.cas_n, st_nxt.we_n} = cmd;
      end
      default:
      begin
      end
    endcase

    // ROM output enable runs one slot into the next cycle to last five periods
    if (s == 3'h0 && st_r.kind == EMCC_K_LIN_RD)
    begin
      st_nxt.oe_n = 1'b0;
      st_nxt.cs_n = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.init <= EMCC_I_PRE;
      st_r.kind <= EMCC_K_IDLE;
      st_r.ras_n <= 1'b1;
      st_r.cas_n <= 1'b1;
      st_r.we_n <= 1'b1;
      st_r.cs_n <= 1'b1;
      st_r.oe_n <= 1'b1;
      st_r.dq_oe_n <= 1'b1;
      // Strobe pins are released in reset, so the row strobe pull level is the strap
      st_r.sdram <= row_strobe_n_in;
    end
    else
      st_r <= st_nxt;
  end

  assign master_clock_out = clk_sys & st_r.sdram;
  assign row_strobe_n_out = st_r.ras_n;
  assign col_strobe_n_out = st_r.cas_n;
  // Strobe pins float during reset so the strap can be sensed
  assign row_strobe_n_oe_n = ~rst_n;
  assign col_strobe_n_oe_n = ~rst_n;
  assign linear_addr = st_r.laddr;
  assign muxed_addr = st_r.maddr;
  assign mem_chip_select_zero_n = st_r.cs_n;
  assign mem_output_enable_n = st_r.oe_n;
  assign mem_write_enable_n = st_r.we_n;
  assign mem_dq_out = st_r.dq;
  assign mem_dq_oe_n = st_r.dq_oe_n;
  assign rd_data = st_r.rd_data;
  assign rd_valid = st_r.rd_valid;

  default clocking emcc_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence emcc_sd_start_s;
    st_r.ras_n && st_r.cas_n && st_r.we_n;
  endsequence

  sequence emcc_sd_rw_tail_s;
    st_r.ras_n && st_r.cas_n && st_r.we_n ##1 st_r.ras_n && st_r.cas_n && st_r.we_n;
  endsequence

  sd_read_seq_a: assert property (
    phase == 3'h0 && st_r.kind == EMCC_K_SD_RD |->
    emcc_sd_start_s ##1 {st_r.ras_n, st_r.cas_n, st_r.we_n} == `EMCC_CMD_ACT
    ##1 emcc_sd_start_s ##1 {st_r.ras_n, st_r.cas_n, st_r.we_n} == `EMCC_CMD_RD
    && st_r.maddr[`EMCC_SD_AP_BIT] ##1 emcc_sd_rw_tail_s)
    else $error("SDRAM read command sequence wrong");

  sd_write_seq_a: assert property (
    phase == 3'h0 && st_r.kind == EMCC_K_SD_WR |->
    emcc_sd_start_s ##1 {st_r.ras_n, st_r.cas_n, st_r.we_n} == `EMCC_CMD_ACT
    ##1 emcc_sd_start_s ##1 {st_r.ras_n, st_r.cas_n, st_r.we_n} == `EMCC_CMD_WR
    && !st_r.dq_oe_n ##1 emcc_sd_rw_tail_s)
    else $error("SDRAM write command sequence wrong");

  sd_refresh_seq_a: assert property (
    phase == 3'h0 && st_r.kind == EMCC_K_SD_REF |->
    emcc_sd_start_s ##1 {st_r.ras_n, st_r.cas_n, st_r.we_n} == `EMCC_CMD_REF
    ##1 (st_r.ras_n && st_r.cas_n && st_r.we_n) [*4])
    else $error("SDRAM refresh command sequence wrong");

  mode_load_value_a: assert property (
    st_r.sdram && {st_r.ras_n, st_r.cas_n, st_r.we_n} == `EMCC_CMD_MRS && !st_r.cs_n |->
    st_r.maddr == `EMCC_SD_MODE)
    else $error("mode register load carries wrong value");

  ras_to_cas_a: assert property (
    $fell(st_r.ras_n) && (st_r.kind == EMCC_K_DR_RD || st_r.kind == EMCC_K_DR_WR) |->
    st_r.cas_n ##1 st_r.cas_n ##1 !st_r.cas_n)
    else $error("CAS does not follow RAS by two clocks");

  ras_precharge_a: assert property (
    $rose(st_r.ras_n) |=> st_r.ras_n)
    else $error("RAS precharge shorter than two clocks");

  early_write_a: assert property (
    $fell(st_r.cas_n) && st_r.kind == EMCC_K_DR_WR |->
    !$past(st_r.we_n, 2) && !$past(st_r.dq_oe_n, 2)
    ##0 (!st_r.we_n && !st_r.dq_oe_n) [*3])
    else $error("early write setup or hold wrong");

  ras_only_refresh_a: assert property (
    st_r.kind == EMCC_K_DR_REF && !st_r.ras_n |-> st_r.cas_n && st_r.maddr == ref_row)
    else $error("CAS active during RAS-only refresh");

  dram_select_a: assert property (
    (!st_r.ras_n || !st_r.cas_n) && !st_r.sdram |-> !st_r.cs_n)
    else $error("chip select zero high while RAS low");

  rom_oe_a: assert property (
    $fell(st_r.oe_n) && st_r.kind == EMCC_K_LIN_RD |->
    !$past(st_r.cs_n, 2) ##0 (!st_r.oe_n) [*5] ##1 st_r.oe_n)
    else $error("ROM output enable timing wrong");

endmodule : emcc_top

// ==== emcc_mem_model.sv ====
`timescale 1ns/1ps

module emcc_mem_model
(
  // Clock and strap
  input wire logic clk_sys,
  input wire logic sdram,
  // Memory pins
  input wire logic [23:0] linear_addr,
  input wire logic [11:0] muxed_addr,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe_n,
  output logic [15:0] dq_in,
  // Event counters
  output int n_ref,
  output int n_bad,
  output int n_aref,
  output int n_mrs
);
  logic [15:0] mem [logic [23:0]];
  logic [11:0] row;
  logic [11:0] last_row;
  logic [23:0] a_q;
  logic ras_q = 1'b1;
  logic cas_q = 1'b1;
  logic cas_seen = 1'b0;
  logic drive;
  int act_age = 9;
  int rd_left = 0;

  initial
  begin
    dq_in = 16'h0000;
    n_ref = 0;
    n_bad = 0;
    n_aref = 0;
    n_mrs = 0;
  end

  // Equal row and column widths; SDRAM loses the column high bits
  function automatic logic [23:0] join_addr(input logic [11:0] r, input logic [11:0] c);
    join_addr = {c[11], r[11], c[10], r[10], c[9], r[9], c[8:0], r[8:0]};
    if (sdram)
      join_addr = join_addr & 24'h57ffff;
  endfunction : join_addr

  function automatic logic [15:0] rd(input logic [23:0] a);
    rd = mem.exists(a) ? mem[a] : a[15:0] ^ a[23:8];
  endfunction : rd

  always @(posedge clk_sys)
  begin
    drive = 1'b0;
    act_age++;
    if (!sdram)
    begin
      if (ras_q && !ras_n)
      begin
        row = muxed_addr;
        cas_seen = 1'b0;
      end
      if (cas_q && !cas_n)
      begin
        cas_seen = 1'b1;
        a_q = join_addr(row, muxed_addr);
        if (!we_n)
        begin
          // Write data must be driven when the column strobe lands
          if (dq_oe_n)
            n_bad++;
          mem[a_q] = dq_out;
        end
      end
      if (!cas_n && we_n)
      begin
        dq_in <= rd(a_q);
        drive = 1'b1;
      end
      // A row cycle with no column strobe is a refresh
      if (!ras_q && ras_n && !cas_seen)
      begin
        if (n_ref > 1 && row !== last_row + 12'h001)
          n_bad++;
        last_row = row;
        n_ref++;
      end
    end
    else if (!cs_n)
    begin
      case ({ras_n, cas_n, we_n})
        3'h3:
        begin
          row = muxed_addr;
          act_age = 0;
        end
        3'h5, 3'h4:
        begin
          if (act_age != 2 || !muxed_addr[10])
            n_bad++;
          a_q = join_addr(row, muxed_addr);
          if (!we_n)
          begin
            if (dq_oe_n)
              n_bad++;
            mem[a_q] = dq_out;
          end
          else
            rd_left = 2;
        end
        3'h1: n_aref++;
        3'h0: if (muxed_addr == 12'h020) n_mrs++; else n_bad++;
        3'h2: if (!muxed_addr[10]) n_bad++;
        default: ;
      endcase
    end
    if (!cs_n && !oe_n)
    begin
      dq_in <= rd(linear_addr);
      drive = 1'b1;
    end
    if (rd_left > 0)
    begin
      dq_in <= rd(a_q);
      rd_left--;
      drive = 1'b1;
    end
    // Released bus never holds a stale word
    if (!drive)
      dq_in <= ~dq_in;
    ras_q = ras_n;
    cas_q = cas_n;
  end
endmodule : emcc_mem_model

// ==== tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
  import emcc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic dram_select = 1'b0;
  logic [23:0] req_addr = 24'h000000;
  logic [15:0] req_wdata = 16'h0000;
  logic strap = 1'b0;
  logic req_ready, rd_valid, cs_n, oe_n, we_n, mclk, ras_out, ras_oe_n, cas_out, cas_oe_n;
  logic dq_oe_n, ras_pin, cas_pin;
  logic [15:0] rd_data, dq_out, dq_in, d;
  logic [23:0] linear_addr, a;
  logic [11:0] muxed_addr;
  logic [23:0] addr_l [8];
  logic [15:0] shadow [logic [23:0]];
  logic [15:0] exp_q [$];
  int n_ref, n_bad, n_aref, n_mrs, n_mismatch, checks_done, base;
  integer seed = 32'hd36716e2;

  always #12.5 clk_sys = ~clk_sys;
  // Strap level shows while the strobe pins are released; column pin pulled up
  assign ras_pin = ras_oe_n ? strap : ras_out;
  assign cas_pin = cas_oe_n ? 1'b1 : cas_out;

  emcc_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .dram_select(dram_select), .req_addr(req_addr),
    .req_wdata(req_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .linear_addr(linear_addr),
    .muxed_addr(muxed_addr), .mem_chip_select_zero_n(cs_n), .mem_output_enable_n(oe_n),
    .mem_write_enable_n(we_n), .master_clock_out(mclk), .row_strobe_n_in(ras_pin),
    .row_strobe_n_out(ras_out), .row_strobe_n_oe_n(ras_oe_n), .col_strobe_n_in(cas_pin),
    .col_strobe_n_out(cas_out), .col_strobe_n_oe_n(cas_oe_n), .mem_dq_in(dq_in),
    .mem_dq_out(dq_out), .mem_dq_oe_n(dq_oe_n));

  emcc_mem_model mem (.clk_sys(clk_sys), .sdram(strap), .linear_addr(linear_addr),
    .muxed_addr(muxed_addr), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .ras_n(ras_pin),
    .cas_n(cas_pin), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in), .n_ref(n_ref),
    .n_bad(n_bad),
    .n_aref(n_aref), .n_mrs(n_mrs));

  task automatic complete_run;
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic note_bad(input string msg);
    n_mismatch++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask : note_bad

  task automatic compare_data(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
      note_bad($sformatf("read data %h, expected %h", got, exp));
  endtask : compare_data

  task automatic compare_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
      note_bad("clock output level");
  endtask : compare_flag

  task automatic compare_count(input int got, input int exp);
    checks_done++;
    if (got != exp)
      note_bad($sformatf("count %0d, expected %0d", got, exp));
  endtask : compare_count

  task automatic do_reset(input logic s, input int n);
    strap <= s;
    rst_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask : do_reset

  // Request stays up until taken at a ready edge; caller lowers it
  task automatic access(input logic w, input logic dsel, input logic [23:0] ad);
    int i;
    d = 16'($random(seed));
    req_valid <= 1'b1;
    req_write <= w;
    dram_select <= dsel;
    req_addr <= ad;
    req_wdata <= d;
    for (i = 0; i < 400; i++)
    begin
      @(posedge clk_sys);
      if (req_ready === 1'b1)
        break;
    end
    if (i == 400)
    begin
      note_bad("request never taken");
      complete_run();
    end
    if (w)
      shadow[ad] = d;
    else
      exp_q.push_back(shadow.exists(ad) ? shadow[ad] : ad[15:0] ^ ad[23:8]);
  endtask : access

  always @(posedge clk_sys)
  begin
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        compare_data(rd_data, 16'hxxxx);
      else
        compare_data(rd_data, exp_q.pop_front());
    end
  end

  initial
  begin
    #1000000;
    note_bad("run limit reached");
    complete_run();
  end

  initial
  begin
    do_reset(1'b0, 12);
    // Look while the clock is high, or a running clock output would pass
    repeat (4) @(posedge clk_sys) #1 compare_flag(mclk, 1'b0);
    @(posedge clk_sys);
    for (int k = 0; k < 8; k++)
    begin
      addr_l[k] = 24'($random(seed));
      access(1'b1, 1'b1, addr_l[k]);
    end
    for (int k = 0; k < 16; k++)
    begin
      a = (k < 8) ? addr_l[k] : 24'($random(seed));
      access(1'b0, k[0], a);
    end
    req_valid <= 1'b0;
    repeat (12) @(posedge clk_sys);
    // Counters are read off the edge so a refresh on the edge is not raced
    @(negedge clk_sys) base = n_ref;
    // Six refresh periods of idle time
    repeat (3072) @(negedge clk_sys);
    compare_count(n_ref - base, 6);
    compare_count(exp_q.size(), 0);
    // 100 us of reset at 25 ns per clock before SDRAM init
    do_reset(1'b1, 4000);
    @(negedge clk_sys) #1 compare_flag(mclk, 1'b0);
    @(posedge clk_sys);
    #1 compare_flag(mclk, 1'b1);
    @(posedge clk_sys);
    for (int k = 0; k < 4; k++)
    begin
      addr_l[k] = 24'($random(seed)) & 24'h57ffff;
      access(1'b1, 1'b1, addr_l[k]);
    end
    compare_count(n_aref, 8);
    compare_count(n_mrs, 2);
    base = n_mrs;
    for (int k = 0; k < 8; k++)
      access(1'b0, k < 4, k < 4 ? addr_l[k] : 24'($random(seed)));
    req_valid <= 1'b0;
    repeat (20) @(posedge clk_sys);
    compare_count(n_mrs, base);
    compare_count(n_bad, 0);
    compare_count(exp_q.size(), 0);
    complete_run();
  end
endmodule : tb_top
